// ---- logic/status_led_indicator.sv ----
// Front-panel status LED driver with APB control and operator button
//
// Function
// - R/E dark in boot, green when running
// - R/E green flash, application idle
// - R/E steady orange in debug run
// - R/E orange flash in debug stop/halt
// - R/E fast orange flash, no application
// - Confirm steady awaiting, 0.8 s flash accepted
// - Input error: confirm flashes 1 Hz 5 s
// - Swap LED off, or count pattern
// - Missing module: 100 ms on/off blink
// - Firmware LED flashes after firmware update
// - Firmware LED steady after key exchange
// - Safety LED on in safe state
// - Safe state freezes the four status LEDs
// - Safety pattern: boot or key missing
// - Safety pattern: pre-operational or not safe-running
// - Safety pattern: safety channel faulty
// - Safety pattern: firmware inoperable or setup
// - Safety pattern: uncertified pilot firmware
// - Safety pattern: engineering tool debug mode
// - Key LED flashes during key access
// - Module scan flashes three LEDs
// - Button held 0.5 s lights confirm
// - Test position lights all while held
`timescale 1ns/10ps
module status_led_indicator #(
   parameter int unsigned TICK_CYC = status_led_pkg::TICK_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        confirmButton,
   input  wire logic        testPosition,
   output logic             runGreenLed,
   output logic             runOrangeLed,
   output logic             confirmLed,
   output logic             moduleSwapLed,
   output logic             firmwareAckLed,
   output logic             safetyStateLed,
   output logic             keyAccessLed
);

   // ======================================================================
   // Pin synchronisers
   logic [1:0] btnSync_r;
   logic [1:0] testSync_r;
   logic       btn;
   logic       testLit;

   always_ff @(posedge clk) begin
      if (rst) begin
         btnSync_r  <= 2'h0;
         testSync_r <= 2'h0;
      end else begin
         btnSync_r  <= {btnSync_r[0], confirmButton};
         testSync_r <= {testSync_r[0], testPosition};
      end
   end

   assign btn     = btnSync_r[1];
   assign testLit = testSync_r[1] & btn;

   // ======================================================================
   // APB slave, one wait-free access phase
   logic [31:0]            ctrl_r;
   logic [31:0]            prdata_r;
   logic                   pready_r;
   logic                   pslverr_r;
   logic                   wrEn;
   logic                   acceptEvt;
   logic                   errorEvt;
   logic                   mapped;
   status_led_pkg::ctrl_t  ctrl;
   status_led_pkg::led_t   led_r;
   logic                   holdLit;

   assign ctrl   = status_led_pkg::ctrl_t'(ctrl_r);
   assign wrEn   = psel & penable & pwrite & pready_r;
   assign mapped = (paddr == status_led_pkg::ADDR_CTRL) |
                   (paddr == status_led_pkg::ADDR_EVT) |
                   (paddr == status_led_pkg::ADDR_STAT);
   assign acceptEvt = wrEn & (paddr == status_led_pkg::ADDR_EVT) &
                      pwdata[status_led_pkg::EVT_ACCEPT];
   assign errorEvt  = wrEn & (paddr == status_led_pkg::ADDR_EVT) &
                      pwdata[status_led_pkg::EVT_ERROR];

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= psel & ~penable;
         pslverr_r <= psel & ~penable & ~mapped;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               status_led_pkg::ADDR_CTRL: prdata_r <= ctrl_r;
               status_led_pkg::ADDR_STAT:
                  prdata_r <= {24'h00_0000, holdLit, led_r};
               default:                   prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= status_led_pkg::CTRL_RST;
      end else if (wrEn && paddr == status_led_pkg::ADDR_CTRL) begin
         ctrl_r <= pwdata;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

   // ======================================================================
   // Prescaler: 100 ms tick, 1 s slot frame, 4 s swap frame
   logic [31:0] preCnt_r;
   logic        tick_r;
   logic [3:0]  slot_r;
   logic [5:0]  frame_r;
   logic        slowOn;
   logic        fastOn;

   always_ff @(posedge clk) begin
      if (rst) begin
         preCnt_r <= 32'h0000_0000;
         tick_r   <= 1'b0;
      end else if (preCnt_r == 32'(TICK_CYC - 1)) begin
         preCnt_r <= 32'h0000_0000;
         tick_r   <= 1'b1;
      end else begin
         preCnt_r <= preCnt_r + 32'h0000_0001;
         tick_r   <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slot_r  <= 4'h0;
         frame_r <= 6'h00;
      end else if (tick_r) begin
         slot_r  <= (slot_r == 4'(status_led_pkg::SLOTS - 1)) ?
                    4'h0 : slot_r + 4'h1;
         frame_r <= (frame_r == 6'(status_led_pkg::SWAP_TICKS - 1)) ?
                    6'h00 : frame_r + 6'h01;
      end
   end

   // Slow is 500 ms on/off, fast is 100 ms on/off
   assign slowOn = slot_r < 4'(status_led_pkg::SLOW_HALF);
   assign fastOn = ~slot_r[0];

   // ======================================================================
   // Operator button hold time, saturating just past the upper limit
   logic [5:0] hold_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         hold_r <= 6'h00;
      end else if (!btn) begin
         hold_r <= 6'h00;
      end else if (tick_r &&
                   hold_r <= 6'(status_led_pkg::HOLD_MAX_TICKS)) begin
         hold_r <= hold_r + 6'h01;
      end
   end

   assign holdLit = btn & (hold_r >= 6'(status_led_pkg::HOLD_TICKS));

   // ======================================================================
   // Confirmation timers; a fresh event reloads even on an expiry tick
   logic [3:0] okTimer_r;
   logic [5:0] errTimer_r;
   logic [3:0] errPhase_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         okTimer_r <= 4'h0;
      end else if (acceptEvt) begin
         okTimer_r <= 4'(status_led_pkg::OK_TICKS);
      end else if (tick_r && okTimer_r != 4'h0) begin
         okTimer_r <= okTimer_r - 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         errTimer_r <= 6'h00;
         errPhase_r <= 4'h0;
      end else if (errorEvt) begin
         errTimer_r <= 6'(status_led_pkg::ERR_TICKS);
         errPhase_r <= 4'h0;
      end else if (tick_r && errTimer_r != 6'h00) begin
         errTimer_r <= errTimer_r - 6'h01;
         errPhase_r <= (errPhase_r ==
                        4'(status_led_pkg::ERR_PER_TICKS - 1)) ?
                       4'h0 : errPhase_r + 4'h1;
      end
   end

   // ======================================================================
   // Swap count pattern: n pulses of 400 ms, then dark to end of frame
   function automatic logic swap_pattern(input logic [2:0] cnt,
                                         input logic [5:0] pos);
      logic [5:0] n;
      n = (cnt > 3'h5) ? 6'h05 : {3'h0, cnt};
      swap_pattern = (pos < 6'(2 * status_led_pkg::SWAP_PULSE) * n) &&
                     (pos % 6'(2 * status_led_pkg::SWAP_PULSE) <
                      6'(status_led_pkg::SWAP_PULSE));
   endfunction

   // ======================================================================
   // LED selection
   status_led_pkg::led_t ledNxt;
   logic                 errLit;

   assign errLit = errPhase_r < 4'(status_led_pkg::ERR_PER_TICKS / 2);

   always_comb begin
      ledNxt = led_r;
      // Safe state keeps the last shown status so the cause stays visible
      if (!ctrl.safeState) begin
         ledNxt.runGreen  = 1'b0;
         ledNxt.runOrange = 1'b0;
         if (ctrl.booting) begin
            ledNxt.runGreen = 1'b0;
         end else if (ctrl.noApp) begin
            ledNxt.runOrange = fastOn;
         end else if (ctrl.dbgRun) begin
            ledNxt.runOrange = 1'b1;
         end else if (ctrl.dbgStop) begin
            ledNxt.runOrange = slowOn;
         end else if (ctrl.appFound && ctrl.appRun) begin
            ledNxt.runGreen = 1'b1;
         end else if (ctrl.appFound) begin
            ledNxt.runGreen = slowOn;
         end

         if (ctrl.scanRun) begin
            ledNxt.confirm = slowOn;
         end else if (errTimer_r != 6'h00) begin
            ledNxt.confirm = errLit;
         end else if (okTimer_r != 4'h0 || holdLit) begin
            ledNxt.confirm = 1'b1;
         end else begin
            ledNxt.confirm = ctrl.awaitConf;
         end

         if (ctrl.scanRun) begin
            ledNxt.moduleSwap = slowOn;
         end else if (ctrl.moduleMissing) begin
            ledNxt.moduleSwap = fastOn;
         end else begin
            ledNxt.moduleSwap = swap_pattern(ctrl.swapCount, frame_r);
         end

         if (ctrl.scanRun) begin
            ledNxt.fwAck = slowOn;
         end else if (ctrl.keySwapped) begin
            ledNxt.fwAck = 1'b1;
         end else if (ctrl.fwUpdated) begin
            ledNxt.fwAck = slowOn;
         end else begin
            ledNxt.fwAck = 1'b0;
         end
      end

      if (ctrl.safeState) begin
         ledNxt.safety = 1'b1;
      end else if (ctrl.booting || ctrl.keyMissing) begin
         ledNxt.safety = status_led_pkg::SAFE_BOOT[slot_r];
      end else if (ctrl.fwInop || ctrl.setupMode) begin
         ledNxt.safety = status_led_pkg::SAFE_INOP[slot_r];
      end else if (ctrl.commFault) begin
         ledNxt.safety = status_led_pkg::SAFE_COMM[slot_r];
      end else if (ctrl.preOp || ctrl.safeOsNotRun) begin
         ledNxt.safety = status_led_pkg::SAFE_PREOP[slot_r];
      end else if (ctrl.pilotFw) begin
         ledNxt.safety = status_led_pkg::SAFE_PILOT[slot_r];
      end else if (ctrl.dbgMode) begin
         ledNxt.safety = status_led_pkg::SAFE_DEBUG[slot_r];
      end else begin
         ledNxt.safety = 1'b0;
      end

      ledNxt.keyAccess = ctrl.keyAccess & slowOn;

      // Lamp test overrides everything, frozen or not
      if (testLit) begin
         ledNxt = '1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         led_r <= '0;
      end else begin
         led_r <= ledNxt;
      end
   end

   assign runGreenLed    = led_r.runGreen;
   assign runOrangeLed   = led_r.runOrange;
   assign confirmLed     = led_r.confirm;
   assign moduleSwapLed  = led_r.moduleSwap;
   assign firmwareAckLed = led_r.fwAck;
   assign safetyStateLed = led_r.safety;
   assign keyAccessLed   = led_r.keyAccess;

   // ======================================================================
   // Checks
   a_boot_dark: assert property (
      @(posedge clk) disable iff (rst)
      (ctrl.booting && !ctrl.safeState && !testLit)
      |=> (!runGreenLed && !runOrangeLed))
      else $error("run LED lit during boot");

   a_run_green: assert property (
      @(posedge clk) disable iff (rst)
      (!ctrl.booting && !ctrl.noApp && !ctrl.dbgRun && !ctrl.dbgStop &&
       ctrl.appFound && ctrl.appRun && !ctrl.safeState && !testLit)
      |=> (runGreenLed && !runOrangeLed))
      else $error("run LED not steady green while executing");

   a_debug_orange: assert property (
      @(posedge clk) disable iff (rst)
      (!ctrl.booting && !ctrl.noApp && ctrl.dbgRun && !ctrl.safeState &&
       !testLit)
      |=> (runOrangeLed && !runGreenLed))
      else $error("run LED not orange in debug run");

   a_safe_freeze: assert property (
      @(posedge clk) disable iff (rst)
      (ctrl.safeState && !testLit && !$past(testLit))
      |=> ($stable(runGreenLed) && $stable(runOrangeLed) &&
           $stable(confirmLed) && $stable(moduleSwapLed) &&
           $stable(firmwareAckLed) && safetyStateLed))
      else $error("status LEDs changed in safe state");

   a_ok_load: assert property (
      @(posedge clk) disable iff (rst)
      acceptEvt |=> (okTimer_r == 4'(status_led_pkg::OK_TICKS)))
      else $error("accept flash not started");

   a_err_load: assert property (
      @(posedge clk) disable iff (rst)
      errorEvt |=> (errTimer_r == 6'(status_led_pkg::ERR_TICKS) &&
                    errPhase_r == 4'h0))
      else $error("error flash not started");

   a_err_first: assert property (
      @(posedge clk) disable iff (rst)
      (errorEvt && !ctrl.safeState && !ctrl.scanRun && !testLit)
      ##1 (!ctrl.safeState && !ctrl.scanRun && !testLit) |=> confirmLed)
      else $error("error flash does not open lit");

   a_key_dark: assert property (
      @(posedge clk) disable iff (rst)
      (!ctrl.keyAccess && !testLit) |=> !keyAccessLed)
      else $error("key LED lit without access");

   a_lamp_test: assert property (
      @(posedge clk) disable iff (rst)
      testLit |=> (runGreenLed && runOrangeLed && confirmLed &&
                   moduleSwapLed && firmwareAckLed && safetyStateLed &&
                   keyAccessLed))
      else $error("lamp test incomplete");

   a_hold_lit: assert property (
      @(posedge clk) disable iff (rst)
      (holdLit && !ctrl.safeState && !ctrl.scanRun &&
       errTimer_r == 6'h00) |=> confirmLed)
      else $error("held button did not light confirm");

   a_tick_gap: assert property (
      @(posedge clk) disable iff (rst)
      tick_r |=> !tick_r)
      else $error("prescaler tick too wide");

endmodule

// ---- logic/status_led_pkg.sv ----
// Shared constants and carrier types for the status LED indicator
package status_led_pkg;

   // ======================================================================
   // Timing
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned TICK_MS        = 100;
   localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned OK_FLASH_MS    = 800;
   localparam int unsigned OK_TICKS       = OK_FLASH_MS / TICK_MS;
   localparam int unsigned ERR_MS         = 5000;
   localparam int unsigned ERR_TICKS      = ERR_MS / TICK_MS;
   localparam int unsigned ERR_FLASH_HZ   = 1;
   localparam int unsigned ERR_PER_TICKS  = 1000 / (ERR_FLASH_HZ * TICK_MS);
   localparam int unsigned HOLD_MIN_MS    = 500;
   localparam int unsigned HOLD_TICKS     = (HOLD_MIN_MS + TICK_MS - 1)
                                            / TICK_MS;
   localparam int unsigned HOLD_MAX_MS    = 5000;
   localparam int unsigned HOLD_MAX_TICKS = HOLD_MAX_MS / TICK_MS;
   localparam int unsigned SAFE_FRAME_MS  = 1000;
   localparam int unsigned SLOTS          = SAFE_FRAME_MS / TICK_MS;
   localparam int unsigned SLOW_HALF      = SLOTS / 2;
   localparam int unsigned SWAP_FRAME_MS  = 4000;
   localparam int unsigned SWAP_TICKS     = SWAP_FRAME_MS / TICK_MS;
   localparam int unsigned SWAP_PULSE_MS  = 400;
   localparam int unsigned SWAP_PULSE     = SWAP_PULSE_MS / TICK_MS;

   // ======================================================================
   // Register map
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_EVT      = 8'h04;
   localparam logic [7:0]  ADDR_STAT     = 8'h08;
   localparam logic [31:0] CTRL_RST      = 32'h0080_0000;
   localparam int unsigned EVT_ACCEPT    = 0;
   localparam int unsigned EVT_ERROR     = 1;

   // ======================================================================
   // Safety LED pulse masks, one bit per 100 ms slot, slot 0 in bit 0
   localparam logic [9:0]  SAFE_BOOT     = 10'h001;
   localparam logic [9:0]  SAFE_PREOP    = 10'h005;
   localparam logic [9:0]  SAFE_COMM     = 10'h015;
   localparam logic [9:0]  SAFE_INOP     = 10'h055;
   localparam logic [9:0]  SAFE_PILOT    = 10'h155;
   localparam logic [9:0]  SAFE_DEBUG    = 10'h01F;

   // ======================================================================
   // Carriers
   typedef struct packed {
      logic [7:0] spare;
      logic       booting;
      logic [2:0] swapCount;
      logic       moduleMissing;
      logic       scanRun;
      logic       keyAccess;
      logic       dbgMode;
      logic       pilotFw;
      logic       setupMode;
      logic       fwInop;
      logic       commFault;
      logic       safeOsNotRun;
      logic       preOp;
      logic       keyMissing;
      logic       safeState;
      logic       keySwapped;
      logic       fwUpdated;
      logic       awaitConf;
      logic       noApp;
      logic       dbgStop;
      logic       dbgRun;
      logic       appRun;
      logic       appFound;
   } ctrl_t;

   typedef struct packed {
      logic runGreen;
      logic runOrange;
      logic confirm;
      logic moduleSwap;
      logic fwAck;
      logic safety;
      logic keyAccess;
   } led_t;

endpackage

// ---- testbench/operator_model.sv ----
// Operator model: confirmation button and selection switch
`timescale 1ns/10ps
module operator_model #(
   parameter int unsigned TICK_CYC = 10
) (
   input  wire logic        clk,
   input  wire logic        pressGo,
   input  wire logic [31:0] holdCyc,
   input  wire logic        testSel,
   output logic             confirmButton,
   output logic             testPosition
);
   int hold;
   int left;
   // ======================================================================
   // Button press
   // A real hand holds between 0.5 s and 5 s, so the request is clipped
   always_comb begin
      hold = holdCyc;
      if (hold < 5 * TICK_CYC) hold = 5 * TICK_CYC;
      if (hold > 50 * TICK_CYC) hold = 50 * TICK_CYC;
   end
   initial begin
      confirmButton = 1'h0;
      left = 0;
   end
   always @(posedge clk) begin
      if (pressGo) begin
         left <= hold;
         confirmButton <= 1'h1;
      end else if (left > 1) begin
         left <= left - 1;
      end else begin
         left <= 0;
         confirmButton <= 1'h0;
      end
   end
   assign testPosition = testSel;
endmodule

// ---- testbench/status_led_indicator_bench.sv ----
// Self-checking bench for the status LED indicator
`timescale 1ns/10ps
module status_led_indicator_bench;
   localparam int TCYC = 10;
   localparam int GRN = 6, ORG = 5, CNF = 4, SWP = 3, FWA = 2, SAF = 1;
   localparam int KEY = 0;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, confirmButton, testPosition;
   logic        pressGo = 1'h0;
   logic        testSel = 1'h0;
   int          holdCyc = 0;
   logic        runGreenLed, runOrangeLed, confirmLed, moduleSwapLed;
   logic        firmwareAckLed, safetyStateLed, keyAccessLed;
   logic [6:0]  ledVec;
   int          badCount = 0;
   int          numChecks = 0;
   logic [31:0] q;
   logic        e;
   int          ones, tog;

   assign ledVec = {runGreenLed, runOrangeLed, confirmLed, moduleSwapLed,
                    firmwareAckLed, safetyStateLed, keyAccessLed};
   always #4 clk = ~clk;

   status_led_indicator #(.TICK_CYC(TCYC)) DUT (.clk, .rst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .confirmButton, .testPosition, .runGreenLed, .runOrangeLed,
      .confirmLed, .moduleSwapLed, .firmwareAckLed, .safetyStateLed,
      .keyAccessLed);
   operator_model #(.TICK_CYC(TCYC)) op (.clk, .pressGo, .holdCyc,
      .testSel, .confirmButton, .testPosition);

   // ======================================================================
   // Compare and report
   task automatic check(input string name, input logic [31:0] exp, got);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR %s expected %0h got %0h", name, exp, got);
      end
   endtask
   task automatic checkRange(input string name, input int lo, hi, got);
      numChecks++;
      if (got < lo || got > hi) begin
         badCount++;
         $display("ERROR %s expected %0d..%0d got %0d", name, lo, hi, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ======================================================================
   // APB master
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         badCount++;
         results();
      end
   endtask

   // ======================================================================
   // LED pattern measurement
   task automatic measure(input int idx, win);
      logic prev;
      ones = 0;
      tog = 0;
      @(negedge clk);
      prev = ledVec[idx];
      for (int i = 0; i < win; i++) begin
         if (ledVec[idx] === 1'h1) ones++;
         if (ledVec[idx] !== prev) tog++;
         prev = ledVec[idx];
         @(negedge clk);
      end
   endtask
   task automatic chk(input logic [31:0] c, input int idx, win, lo, hi,
                      tlo, thi);
      apb(1'h1, status_led_pkg::ADDR_CTRL, c);
      repeat (20) @(posedge clk);
      measure(idx, win);
      checkRange("led on cycles", lo, hi, ones);
      checkRange("led toggles", tlo, thi, tog);
   endtask

   // ======================================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      apb(1'h0, status_led_pkg::ADDR_CTRL, 32'h0);
      check("ctrl reset", status_led_pkg::CTRL_RST, q);
      apb(1'h0, status_led_pkg::ADDR_EVT, 32'h0);
      check("event readback", 32'h0, q);
      apb(1'h1, 8'h0C, 32'hFFFF_FFFF);
      check("unmapped write err", 32'h1, {31'h0, e});
      apb(1'h0, 8'h0C, 32'h0);
      check("unmapped read", 32'h0000_0000, q);
      check("unmapped read err", 32'h1, {31'h0, e});
      apb(1'h0, status_led_pkg::ADDR_CTRL, 32'h0);
      check("ctrl kept", status_led_pkg::CTRL_RST, q);
      chk(32'h0080_0003, GRN, 200, 0, 0, 0, 0);
      chk(32'h0080_0003, SAF, 200, 20, 20, 3, 4);
      chk(32'h0080_2000, SAF, 200, 20, 20, 3, 4);
      chk(32'h0000_0003, GRN, 200, 200, 200, 0, 0);
      apb(1'h0, status_led_pkg::ADDR_STAT, 32'h0);
      check("status word", 32'h0000_0040, q);
      chk(32'h0000_0003, SAF, 200, 0, 0, 0, 0);
      chk(32'h0000_0003, KEY, 200, 0, 0, 0, 0);
      chk(32'h0000_0001, GRN, 200, 100, 100, 3, 4);
      chk(32'h0000_0005, ORG, 200, 200, 200, 0, 0);
      chk(32'h0000_0009, ORG, 200, 100, 100, 3, 4);
      chk(32'h0000_0010, ORG, 200, 100, 100, 19, 20);
      chk(32'h0000_0020, CNF, 200, 200, 200, 0, 0);
      chk(32'h0000_0040, FWA, 200, 100, 100, 3, 20);
      chk(32'h0000_0080, FWA, 200, 200, 200, 0, 0);
      chk(32'h0000_0003, GRN, 200, 200, 200, 0, 0);
      chk(32'h0000_0100, SAF, 200, 200, 200, 0, 0);
      chk(32'h0000_0103, GRN, 200, 200, 200, 0, 0);
      chk(32'h0000_0110, GRN, 200, 200, 200, 0, 0);
      chk(32'h0000_0110, ORG, 200, 0, 0, 0, 0);
      chk(32'h0000_0200, SAF, 200, 20, 20, 3, 4);
      chk(32'h0000_0400, SAF, 200, 40, 40, 7, 8);
      chk(32'h0000_0800, SAF, 200, 40, 40, 7, 8);
      chk(32'h0000_1000, SAF, 200, 60, 60, 11, 12);
      chk(32'h0000_4000, SAF, 200, 80, 80, 15, 16);
      chk(32'h0000_8000, SAF, 200, 100, 100, 19, 20);
      chk(32'h0001_0000, SAF, 200, 100, 100, 3, 4);
      chk(32'h0002_0000, KEY, 200, 100, 100, 3, 20);
      chk(32'h0004_0000, CNF, 200, 100, 100, 3, 20);
      chk(32'h0004_0000, SWP, 200, 100, 100, 3, 20);
      chk(32'h0004_0000, FWA, 200, 100, 100, 3, 20);
      chk(32'h0008_0000, SWP, 200, 100, 100, 19, 20);
      chk(32'h0000_0000, SWP, 400, 0, 0, 0, 0);
      for (int n = 1; n <= 5; n++) begin
         chk(n << 20, SWP, 400, 40 * n, 40 * n, 2 * n - 1, 2 * n);
      end
      apb(1'h1, status_led_pkg::ADDR_EVT, 32'h1);
      measure(CNF, 200);
      checkRange("accept on cycles", 71, 81, ones);
      checkRange("accept toggles", 1, 2, tog);
      apb(1'h1, status_led_pkg::ADDR_EVT, 32'h2);
      measure(CNF, 600);
      checkRange("error on cycles", 240, 260, ones);
      checkRange("error toggles", 9, 10, tog);
      measure(CNF, 100);
      checkRange("error stopped", 0, 0, ones);
      apb(1'h1, status_led_pkg::ADDR_CTRL, 32'h0000_0003);
      holdCyc <= 300;
      pressGo <= 1'h1;
      @(posedge clk);
      pressGo <= 1'h0;
      repeat (35) @(negedge clk);
      check("confirm early", 32'h0, {31'h0, confirmLed});
      repeat (40) @(negedge clk);
      check("confirm held", 32'h1, {31'h0, confirmLed});
      apb(1'h0, status_led_pkg::ADDR_STAT, 32'h0);
      check("hold status", 32'h1, {31'h0, q[7]});
      @(posedge clk);
      testSel <= 1'h1;
      repeat (6) @(negedge clk);
      check("lamp test", 32'h7F, {25'h0, ledVec});
      @(posedge clk);
      testSel <= 1'h0;
      repeat (300) @(posedge clk);
      check("lamp released", 32'h40, {25'h0, ledVec});
      results();
   end
endmodule
